// File: core/loop_reg_set.sv
// One loop register set: start, end and iteration count
`timescale 1ns/1ns
module loop_reg_set
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Setup writes
  input wire logic wr_start_i,
  input wire logic wr_end_i,
  input wire logic wr_count_i,
  input wire logic [zol_pkg::XLEN-1:0] start_val_i,
  input wire logic [zol_pkg::XLEN-1:0] end_val_i,
  input wire logic [zol_pkg::XLEN-1:0] count_val_i,
  // Last body instruction retired
  input wire logic dec_i,
  // Register contents
  output zol_pkg::loop_set_t set_o
);

  // State and its next value
  zol_pkg::loop_set_t state;
  zol_pkg::loop_set_t next_state;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Setup writes win over a decrement in the same cycle; software may not
  // reprogram a set from its own body, so the clash is undefined anyway
  always_comb
  begin
    next_state = state;
    if (dec_i)
    begin
      next_state.loop_iter_count = state.loop_iter_count - zol_pkg::CNT_ONE;
    end
    if (wr_start_i)
    begin
      next_state.loop_start_addr = start_val_i;
    end
    if (wr_end_i)
    begin
      next_state.loop_end_addr = end_val_i;
    end
    if (wr_count_i)
    begin
      next_state.loop_iter_count = count_val_i;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // counts cleared, no loop live
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign set_o = state;

endmodule : loop_reg_set

// File: core/zero_overhead_loop_controller.sv
// Zero-overhead loop controller with two nested sets and AHB-Lite view
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns

// Overview of operation
// - Constraint breaches raise nothing; undefined
// - Set active whenever its count exceeds zero
// - Combined setup writes all three together
// - Loop registers readable through read-only CSRs
// - CSR write to loop register is illegal
// - Interrupt-cancelled last instruction changes nothing
// - Single-step updates PC and count normally
// - Two sets; set 0 has priority
// - Last instruction decrements, redirects without stall
// - Loop logic exists only when enabled
module zero_overhead_loop_controller #(
  parameter bit custom_ext_enable_param = 1'b1
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Decode: loop setup instructions
  input wire zol_pkg::setup_req_t setup_i,
  // CSR stage access
  input wire zol_pkg::csr_req_t csr_i,
  output logic [zol_pkg::XLEN-1:0] csr_rdata_o,
  output logic csr_hit_o,
  output logic csr_illegal_o,
  // Execute: retiring instruction
  input wire zol_pkg::retire_t retire_i,
  // Fetch redirect
  output logic redirect_valid_o,
  output logic [zol_pkg::XLEN-1:0] redirect_pc_o,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [zol_pkg::AHB_ADDR_W-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [zol_pkg::XLEN-1:0] hwdata_i,
  input wire logic hready_i,
  output logic [zol_pkg::XLEN-1:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr_pend;                          // AHB write in data phase
    logic [zol_pkg::REG_OFF_W-1:0] wr_off;  // Its register offset
    logic [zol_pkg::XLEN-1:0] hrdata;       // Read data for data phase
    logic run;                              // Control run bit
    logic redirect_valid;                   // Fetch redirect pulse
    logic [zol_pkg::XLEN-1:0] redirect_pc;  // Redirect target
    logic [zol_pkg::XLEN-1:0] csr_rdata;    // CSR read data
    logic csr_hit;                          // CSR number is a loop register
    logic csr_illegal;                      // Illegal CSR write pulse
  } ctl_state_t;

  ctl_state_t state;
  ctl_state_t next_state;

  // Loop sets and per-set controls
  zol_pkg::loop_set_t sets [zol_pkg::LOOP_SETS];
  logic [zol_pkg::LOOP_SETS-1:0] active;  // Count above zero
  logic [zol_pkg::LOOP_SETS-1:0] at_last; // Retiring PC is last body word
  logic [zol_pkg::LOOP_SETS-1:0] dec;     // Decrement this set
  logic [zol_pkg::LOOP_SETS-1:0] wr_st;
  logic [zol_pkg::LOOP_SETS-1:0] wr_en;
  logic [zol_pkg::LOOP_SETS-1:0] wr_ct;
  logic take;       // Retire that may step a loop
  logic csr_loop;   // CSR number inside loop range
  logic ahb_addr_ph; // Valid AHB address phase
  logic csr_wr_loop; // Write to a loop CSR this cycle

  // ----------------------------------------------------------------
  // Loop register sets
  // ----------------------------------------------------------------
  // whole engine gated by the build option
  assign take = custom_ext_enable_param && state.run && retire_i.valid && !retire_i.cancel;

  for (genvar g = 0; g < zol_pkg::LOOP_SETS; g++)
  begin : g_set
    logic sel;
    assign sel = custom_ext_enable_param && setup_i.valid && (32'(setup_i.set_sel) == g);
    assign wr_st[g] = sel && (setup_i.op inside {zol_pkg::SETUP_START, zol_pkg::SETUP_COMBINED});
    assign wr_en[g] = sel && (setup_i.op inside {zol_pkg::SETUP_END, zol_pkg::SETUP_COMBINED});
    assign wr_ct[g] = sel && (setup_i.op inside {zol_pkg::SETUP_COUNT, zol_pkg::SETUP_COMBINED});
    assign active[g] = sets[g].loop_iter_count != zol_pkg::CNT_ZERO;
    // Only an equality compare; no range checks, which keeps area low
    assign at_last[g] = active[g]
      && (retire_i.pc == sets[g].loop_end_addr - zol_pkg::INSN_BYTES);

    loop_reg_set u_set (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .wr_start_i(wr_st[g]),
      .wr_end_i(wr_en[g]),
      .wr_count_i(wr_ct[g]),
      .start_val_i(setup_i.start_addr),
      .end_val_i(setup_i.end_addr),
      .count_val_i(setup_i.count),
      .dec_i(dec[g]),
      .set_o(sets[g])
    );
  end

  // set 0 wins when both match
  assign dec[0] = take && at_last[0];
  assign dec[1] = take && at_last[1] && !at_last[0];

  assign csr_loop = (csr_i.addr >= zol_pkg::CSR_LOOP_BASE)
    && (csr_i.addr <= zol_pkg::CSR_LOOP_LAST);
  assign ahb_addr_ph = hsel_i && htrans_i[zol_pkg::HTRANS_ACTIVE_BIT] && hready_i;
  assign csr_wr_loop = csr_i.valid && csr_i.write && csr_loop;

  // ----------------------------------------------------------------
  // Read multiplexers
  // ----------------------------------------------------------------
  // AHB register view, unmapped offsets read zero
  function automatic logic [zol_pkg::XLEN-1:0] ahb_read(
    input logic [zol_pkg::REG_OFF_W-1:0] off
  );
    logic [zol_pkg::XLEN-1:0] d;
    d = '0;
    unique case (off)
      zol_pkg::OFF_START0: d = sets[0].loop_start_addr;
      zol_pkg::OFF_END0: d = sets[0].loop_end_addr;
      zol_pkg::OFF_COUNT0: d = sets[0].loop_iter_count;
      zol_pkg::OFF_START1: d = sets[1].loop_start_addr;
      zol_pkg::OFF_END1: d = sets[1].loop_end_addr;
      zol_pkg::OFF_COUNT1: d = sets[1].loop_iter_count;
      zol_pkg::OFF_CTRL: d[zol_pkg::CTRL_RUN_BIT] = state.run;
      zol_pkg::OFF_STATUS: d[zol_pkg::LOOP_SETS-1:0] = active;
      default: d = '0;
    endcase
    return d;
  endfunction : ahb_read

  // CSR view: set index and field from the CSR number
  function automatic logic [zol_pkg::XLEN-1:0] csr_read(
    input logic [zol_pkg::CSR_ADDR_W-1:0] num
  );
    logic [zol_pkg::CSR_ADDR_W-1:0] rel;
    logic sel;
    logic [1:0] fld;
    rel = num - zol_pkg::CSR_LOOP_BASE;
    sel = rel >= zol_pkg::CSR_SET_STRIDE;
    fld = sel ? 2'(rel - zol_pkg::CSR_SET_STRIDE) : 2'(rel);
    unique case (fld)
      zol_pkg::FLD_START: csr_read = sets[sel].loop_start_addr;
      zol_pkg::FLD_END: csr_read = sets[sel].loop_end_addr;
      zol_pkg::FLD_COUNT: csr_read = sets[sel].loop_iter_count;
      default: csr_read = '0;
    endcase
  endfunction : csr_read

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_state.redirect_valid = 1'b0;
    next_state.csr_illegal = 1'b0;
    // jump back to start, no bubble inserted here
    // a single step takes this same path, step is not looked at
    if (dec[0])
    begin
      // last pass falls through to the end address
      next_state.redirect_valid = sets[0].loop_iter_count != zol_pkg::CNT_ONE;
      next_state.redirect_pc = sets[0].loop_start_addr;
    end
    else if (dec[1])
    begin
      next_state.redirect_valid = sets[1].loop_iter_count != zol_pkg::CNT_ONE;
      next_state.redirect_pc = sets[1].loop_start_addr;
    end
    // CSR stage: registered answer one cycle after the request
    if (csr_i.valid)
    begin
      next_state.csr_hit = custom_ext_enable_param && csr_loop;
      next_state.csr_rdata = (custom_ext_enable_param && csr_loop) ? csr_read(csr_i.addr) : '0;
      // writes to loop CSRs are illegal
      next_state.csr_illegal = custom_ext_enable_param && csr_loop && csr_i.write;
    end
    // AHB data phase of a write; only the control word is writable
    if (state.wr_pend && (state.wr_off == zol_pkg::OFF_CTRL))
    begin
      next_state.run = hwdata_i[zol_pkg::CTRL_RUN_BIT];
    end
    // AHB address phase; read data registered for the data phase
    next_state.wr_pend = ahb_addr_ph && hwrite_i;
    if (ahb_addr_ph)
    begin
      next_state.wr_off = haddr_i[zol_pkg::REG_OFF_W-1:0];
      next_state.hrdata = hwrite_i ? '0 : ahb_read(haddr_i[zol_pkg::REG_OFF_W-1:0]);
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state <= '0;
      state.run <= zol_pkg::CTRL_RUN_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Ready and response never change: zero-wait slave, always OKAY
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= zol_pkg::HRESP_OKAY;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= zol_pkg::HRESP_OKAY;
    end
  end

  // no violation detection, hence no error outputs
  assign hrdata_o = state.hrdata;
  assign redirect_valid_o = state.redirect_valid;
  assign redirect_pc_o = state.redirect_pc;
  assign csr_rdata_o = state.csr_rdata;
  assign csr_hit_o = state.csr_hit;
  assign csr_illegal_o = state.csr_illegal;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_hit0_more;
    take && at_last[0] && (sets[0].loop_iter_count > zol_pkg::CNT_ONE);
  endsequence
  sequence s_hit0_last;
    take && at_last[0] && (sets[0].loop_iter_count == zol_pkg::CNT_ONE);
  endsequence

  a_loop_back_jump: assert property (
    s_hit0_more |=> redirect_valid_o && (redirect_pc_o == $past(sets[0].loop_start_addr))
  ) else $error("loop back redirect missing or wrong");

  a_last_pass_exit: assert property (
    s_hit0_last |=> !redirect_valid_o && (sets[0].loop_iter_count == zol_pkg::CNT_ZERO)
  ) else $error("last pass did not fall through");

  a_cancel_no_effect: assert property (
    retire_i.valid && retire_i.cancel && !setup_i.valid
      |=> !redirect_valid_o && $stable(sets[0].loop_iter_count) && $stable(sets[1].loop_iter_count)
  ) else $error("cancelled instruction changed loop state");

  a_step_same_path: assert property (
    (s_hit0_more and retire_i.step) |=> redirect_valid_o
  ) else $error("single step skipped loop redirect");

  a_inner_priority: assert property (
    take && at_last[0] && !setup_i.valid |=> $stable(sets[1].loop_iter_count)
  ) else $error("outer set stepped while inner matched");

  a_idle_no_jump: assert property (
    retire_i.valid && !active[0] && !active[1] |=> !redirect_valid_o
  ) else $error("redirect with no active loop");

  a_combined_all: assert property (
    setup_i.valid && (setup_i.op == zol_pkg::SETUP_COMBINED) && !setup_i.set_sel
      && custom_ext_enable_param
      |=> (sets[0].loop_start_addr == $past(setup_i.start_addr))
      && (sets[0].loop_end_addr == $past(setup_i.end_addr))
      && (sets[0].loop_iter_count == $past(setup_i.count))
  ) else $error("combined setup did not load all three");

  a_csr_write_trap: assert property (
    csr_wr_loop && custom_ext_enable_param
      |=> csr_illegal_o ##1 (!csr_illegal_o || $past(csr_wr_loop))
  ) else $error("loop CSR write not flagged once");

  a_csr_read_count: assert property (
    csr_i.valid && custom_ext_enable_param
      && (csr_i.addr == zol_pkg::CSR_LOOP_BASE + 12'(zol_pkg::FLD_COUNT))
      |=> csr_rdata_o == $past(sets[0].loop_iter_count)
  ) else $error("loop count CSR read wrong");

endmodule : zero_overhead_loop_controller

// File: core/zol_pkg.sv
// Shared constants, types and carriers of the zero-overhead loop controller
package zol_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int XLEN = 32;
  localparam int LOOP_SETS = 2;
  localparam int CSR_ADDR_W = 12;
  localparam int AHB_ADDR_W = 32;
  localparam int REG_OFF_W = 5;

  // Instruction size, used to find the last body word from the end address
  localparam logic [XLEN-1:0] INSN_BYTES = 32'h0000_0004;
  // Count values with special meaning
  localparam logic [XLEN-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [XLEN-1:0] CNT_ONE = 32'h0000_0001;

  // ----------------------------------------------------------------
  // Loop CSR numbers, read-only custom space, three per set
  // ----------------------------------------------------------------
  localparam logic [CSR_ADDR_W-1:0] CSR_LOOP_BASE = 12'hCE0;
  localparam logic [CSR_ADDR_W-1:0] CSR_LOOP_LAST = 12'hCE5;
  localparam logic [CSR_ADDR_W-1:0] CSR_SET_STRIDE = 12'h003;
  localparam logic [1:0] FLD_START = 2'h0;
  localparam logic [1:0] FLD_END = 2'h1;
  localparam logic [1:0] FLD_COUNT = 2'h2;

  // ----------------------------------------------------------------
  // AHB-Lite register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [REG_OFF_W-1:0] OFF_START0 = 5'h00;
  localparam logic [REG_OFF_W-1:0] OFF_END0 = 5'h04;
  localparam logic [REG_OFF_W-1:0] OFF_COUNT0 = 5'h08;
  localparam logic [REG_OFF_W-1:0] OFF_START1 = 5'h0C;
  localparam logic [REG_OFF_W-1:0] OFF_END1 = 5'h10;
  localparam logic [REG_OFF_W-1:0] OFF_COUNT1 = 5'h14;
  localparam logic [REG_OFF_W-1:0] OFF_CTRL = 5'h18;
  localparam logic [REG_OFF_W-1:0] OFF_STATUS = 5'h1C;
  // Control field: loop engine run bit, and its reset value
  localparam int CTRL_RUN_BIT = 0;
  localparam logic CTRL_RUN_RESET = 1'b1;
  // AHB transfer type bit that marks NONSEQ or SEQ
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SETUP_START,
    SETUP_END,
    SETUP_COUNT,
    SETUP_COMBINED
  } setup_op_t;

  // One loop register set
  typedef struct packed {
    logic [XLEN-1:0] loop_start_addr;
    logic [XLEN-1:0] loop_end_addr;
    logic [XLEN-1:0] loop_iter_count;
  } loop_set_t;

  // Loop setup instruction from decode
  typedef struct packed {
    logic valid;
    logic set_sel;
    setup_op_t op;
    logic [XLEN-1:0] start_addr;
    logic [XLEN-1:0] end_addr;
    logic [XLEN-1:0] count;
  } setup_req_t;

  // CSR access from the CSR stage
  typedef struct packed {
    logic valid;
    logic write;
    logic [CSR_ADDR_W-1:0] addr;
  } csr_req_t;

  // Instruction leaving execute
  typedef struct packed {
    logic valid;
    logic cancel;
    logic step;
    logic [XLEN-1:0] pc;
  } retire_t;

endpackage : zol_pkg

// File: tb/loop_program_model.sv
// Behavioural model of the program that sets up and runs one loop
`timescale 1ns/1ns
module loop_program_model
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Loop to run
  input wire logic go_i,
  input wire logic set_sel_i,
  input wire logic [31:0] start_i,
  input wire logic [31:0] end_i,
  input wire logic [31:0] count_i,
  // Fetch redirect
  input wire logic redirect_valid_i,
  input wire logic [31:0] redirect_pc_i,
  // Instruction stream
  output zol_pkg::setup_req_t setup_o,
  output zol_pkg::retire_t retire_o,
  output logic done_o,
  output logic [31:0] n_retired_o
);
  logic [1:0] phase; // 0 idle, 1 issue, 2 bubble, 3 decide
  logic [31:0] pc; // Next body word

  // -------------------------------------------------------------
  // Program sequencer, slow pace so the redirect is seen first
  // -------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      setup_o <= '0;
      retire_o <= '0;
      done_o <= 1'b0;
      n_retired_o <= '0;
      phase <= 2'd0;
      pc <= '0;
    end
    else
    begin
      // Idle setup lines other than valid, and the retire PC lines, never keep their last value
      setup_o <= zol_pkg::setup_req_t'(~setup_o);
      setup_o.valid <= 1'b0;
      retire_o.valid <= 1'b0;
      retire_o.pc <= ~retire_o.pc;
      if (go_i)
      begin
        // end above start, one past a three-word body
        // one combined setup, count never before addresses
        setup_o <= '{1'b1, set_sel_i, zol_pkg::SETUP_COMBINED, start_i, end_i, count_i};
        // body entered at its start only
        pc <= start_i;
        done_o <= 1'b0;
        n_retired_o <= '0;
        phase <= 2'd1;
      end
      else if (phase == 2'd1)
      begin
        // plain straight-line words, no cancel or step
        retire_o <= '{1'b1, 1'b0, 1'b0, pc};
        n_retired_o <= n_retired_o + 32'h0000_0001;
        phase <= 2'd2;
      end
      else if (phase == 2'd2)
        phase <= 2'd3;
      else if (phase == 2'd3)
      begin
        phase <= 2'd1;
        // no setup while the loop runs; word steps
        if (pc != end_i - 32'h0000_0004)
          pc <= pc + 32'h0000_0004;
        else if (redirect_valid_i)
          pc <= redirect_pc_i;
        else
        begin
          done_o <= 1'b1;
          phase <= 2'd0;
        end
      end
    end
  end
endmodule : loop_program_model

// File: tb/zero_overhead_loop_controller_tb.sv
// Self-checking testbench of the zero-overhead loop controller
`timescale 1ns/1ns
module zero_overhead_loop_controller_tb;
  // -------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------
  logic clk_sys_i;
  logic rst_b_i;
  zol_pkg::setup_req_t tb_setup;
  zol_pkg::setup_req_t p_setup;
  zol_pkg::setup_req_t setup_w;
  zol_pkg::csr_req_t csr;
  zol_pkg::retire_t tb_retire;
  zol_pkg::retire_t p_retire;
  zol_pkg::retire_t retire_w;
  logic [31:0] csr_rdata;
  logic csr_hit;
  logic csr_ill;
  logic redir_v;
  logic [31:0] redir_pc;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic go;
  logic p_done;
  logic [31:0] p_nret;
  logic [31:0] rd;
  int n_mismatch;
  int num_checks;

  // Partner owns the stream while it runs a loop
  assign setup_w = p_setup.valid ? p_setup : tb_setup;
  assign retire_w = p_retire.valid ? p_retire : tb_retire;

  zero_overhead_loop_controller #(.custom_ext_enable_param(1'b1)) dut
  (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .setup_i(setup_w), .csr_i(csr),
    .csr_rdata_o(csr_rdata), .csr_hit_o(csr_hit), .csr_illegal_o(csr_ill),
    .retire_i(retire_w), .redirect_valid_o(redir_v), .redirect_pc_o(redir_pc),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
    .hreadyout_o(hreadyout), .hresp_o(hresp)
  );

  loop_program_model prog
  (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .go_i(go), .set_sel_i(1'b0),
    .start_i(32'h0000_0100), .end_i(32'h0000_010C), .count_i(32'h0000_0003),
    .redirect_valid_i(redir_v), .redirect_pc_i(redir_pc), .setup_o(p_setup),
    .retire_o(p_retire), .done_o(p_done), .n_retired_o(p_nret)
  );

  // -------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report();
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  // Bounded wait for hready at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk_sys_i);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        n_mismatch++;
        final_report();
      end
      @(posedge clk_sys_i);
    end
  endtask : wait_rdy

  // Single AHB-Lite word transfer
  task automatic ahb(input logic wr, input logic [4:0] off, input logic [31:0] wd);
    @(posedge clk_sys_i);
    hsel <= 1'b1;
    haddr <= {27'h0, off};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask : ahb

  // Read or write one CSR number
  task automatic csr_op(input logic [11:0] a, input logic wr, input logic [31:0] ed,
                        input logic eh);
    @(posedge clk_sys_i);
    csr <= '{1'b1, wr, a};
    @(posedge clk_sys_i);
    csr <= '0;
    #1;
    if (!wr && eh)
      chk(csr_rdata, ed);
    if (!wr)
      chk({31'h0, csr_hit}, {31'h0, eh});
    chk({31'h0, csr_ill}, {31'h0, wr & eh});
  endtask : csr_op

  task automatic csr_rd(input int s, input int f, input logic [31:0] ed);
    csr_op(zol_pkg::CSR_LOOP_BASE + 12'(3 * s + f), 1'b0, ed, 1'b1);
  endtask : csr_rd

  task automatic setup(input logic s, input zol_pkg::setup_op_t op, input logic [31:0] a,
                       input logic [31:0] e, input logic [31:0] c);
    @(posedge clk_sys_i);
    tb_setup <= '{1'b1, s, op, a, e, c};
    @(posedge clk_sys_i);
    tb_setup <= '0;
  endtask : setup

  // Retire one word and look at the redirect pulse
  task automatic ret(input logic c, input logic st, input logic [31:0] pc, input logic ev,
                     input logic [31:0] epc);
    @(posedge clk_sys_i);
    tb_retire <= '{1'b1, c, st, pc};
    @(posedge clk_sys_i);
    tb_retire <= '0;
    #1;
    chk({31'h0, redir_v}, {31'h0, ev});
    if (ev)
      chk(redir_pc, epc);
  endtask : ret

  // -------------------------------------------------------------
  // Clock
  // -------------------------------------------------------------
  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial
  begin
    int n;
    n_mismatch = 0;
    num_checks = 0;
    rst_b_i = 1'b0;
    tb_setup = '0;
    tb_retire = '0;
    csr = '0;
    {hsel, haddr, htrans, hwrite, hsize, hwdata, go} = '0;
    repeat (20) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 6; i++) csr_rd(i / 3, i % 3, 32'h0000_0000);
    ahb(1'b0, zol_pkg::OFF_CTRL, 32'h0);
    chk(rd, 32'h0000_0001);
    // outer set 1 built one field at a time, end 8 past inner end
    setup(1'b1, zol_pkg::SETUP_START, 32'h0000_00F0, 32'h0, 32'h0);
    setup(1'b1, zol_pkg::SETUP_END, 32'h0, 32'h0000_0114, 32'h0);
    ahb(1'b0, zol_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h0000_0000);
    setup(1'b1, zol_pkg::SETUP_COUNT, 32'h0, 32'h0, 32'h0000_0002);
    ahb(1'b0, zol_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h0000_0002);
    csr_rd(1, 0, 32'h0000_00F0);
    csr_rd(1, 1, 32'h0000_0114);
    ahb(1'b0, zol_pkg::OFF_COUNT1, 32'h0);
    chk(rd, 32'h0000_0002);
    csr_op(12'hCE4, 1'b1, 32'h0, 1'b1);
    csr_rd(1, 1, 32'h0000_0114);
    csr_op(12'h300, 1'b0, 32'h0, 1'b0);
    // Partner runs the inner loop three times over three words
    @(posedge clk_sys_i);
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (p_done !== 1'b1 && n < 200);
    if (n >= 200)
    begin
      n_mismatch++;
      final_report();
    end
    chk(p_nret, 32'h0000_0009);
    csr_rd(0, 2, 32'h0000_0000);
    csr_rd(1, 2, 32'h0000_0002);
    // Combined setup then cancel, step and exit on the last word
    setup(1'b0, zol_pkg::SETUP_COMBINED, 32'h0000_0100, 32'h0000_010C, 32'h0000_0002);
    csr_rd(0, 0, 32'h0000_0100);
    ret(1'b1, 1'b0, 32'h0000_0108, 1'b0, 32'h0);
    csr_rd(0, 2, 32'h0000_0002);
    ret(1'b0, 1'b1, 32'h0000_0108, 1'b1, 32'h0000_0100);
    ret(1'b0, 1'b0, 32'h0000_0104, 1'b0, 32'h0);
    ret(1'b0, 1'b0, 32'h0000_0108, 1'b0, 32'h0);
    csr_rd(0, 2, 32'h0000_0000);
    // Trap on the last word; handler takes one pass off and resumes at the last word
    setup(1'b0, zol_pkg::SETUP_COMBINED, 32'h0000_0100, 32'h0000_010C, 32'h0000_0002);
    ret(1'b1, 1'b0, 32'h0000_0108, 1'b0, 32'h0);
    setup(1'b0, zol_pkg::SETUP_COUNT, 32'h0, 32'h0, 32'h0000_0001);
    csr_rd(0, 2, 32'h0000_0001);
    ret(1'b0, 1'b0, 32'h0000_0108, 1'b0, 32'h0);
    csr_rd(0, 2, 32'h0000_0000);
    // Engine stopped, then outer loop on its last word
    ahb(1'b1, zol_pkg::OFF_CTRL, 32'h0000_0000);
    ret(1'b0, 1'b0, 32'h0000_0110, 1'b0, 32'h0);
    csr_rd(1, 2, 32'h0000_0002);
    ahb(1'b1, zol_pkg::OFF_CTRL, 32'h0000_0001);
    ret(1'b0, 1'b0, 32'h0000_0110, 1'b1, 32'h0000_00F0);
    ret(1'b0, 1'b0, 32'h0000_0110, 1'b0, 32'h0);
    ahb(1'b0, zol_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h0000_0000);
    // Reset in mid-run clears a live count
    setup(1'b0, zol_pkg::SETUP_COMBINED, 32'h0000_0100, 32'h0000_010C, 32'h0000_0005);
    @(posedge clk_sys_i);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    csr_rd(0, 2, 32'h0000_0000);
    final_report();
  end
endmodule : zero_overhead_loop_controller_tb
